// ===== gspsc_system_control.sv
// System control: local clocks, interrupt levels and reset start-up
`timescale 1ns/10ps
`default_nettype none
module gspsc_system_control
  import gspsc_pkg::*;
#(
  parameter int QUARTER_CYC = QUARTER_CYC_DEF
) (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RSTN_I,
  input  wire logic       VIDEO_CLOCK_I,
  input  wire logic       EXT_IRQ_LEVEL_A_N_I,
  input  wire logic       EXT_IRQ_LEVEL_B_N_I,
  input  wire logic [1:0] IRQ_ACK_I,
  input  wire logic       HOST_SELECT_STROBE_I,
  input  wire logic       HALT_BIT_WR_I,
  input  wire logic       HALT_BIT_WDATA_I,
  output var  logic       LOCAL_CLOCK_A_O,
  output var  logic       LOCAL_CLOCK_B_O,
  output var  logic [1:0] IRQ_REQ_O,
  output var  logic       VECTOR_FETCH_O,
  output var  logic       RUN_O,
  output var  logic       HALT_BIT_O,
  output var  logic       VIDEO_TICK_O
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (QUARTER_CYC < 1 || QUARTER_CYC > 255) begin : g_bad_div
    $error("QUARTER_CYC must lie in 1..255");
  end

  // ----------------------------------------------------------------
  // Quarter-period divider
  // ----------------------------------------------------------------
  localparam logic [QUARTER_W-1:0] QUARTER_LAST = QUARTER_W'(QUARTER_CYC - 1);

  logic [QUARTER_W-1:0] div_q;
  logic [QUARTER_W-1:0] div_d;
  logic                 tick;

  assign tick  = (div_q == QUARTER_LAST);
  assign div_d = tick ? '0 : div_q + QUARTER_W'(1);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // Quadrature local clocks
  // ----------------------------------------------------------------
  // Decoding the binary phase count into a Gray sequence gives exactly one quarter period between
  // the edges of the two clocks, so neither ever glitches.
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;
  logic               clk_a_d;
  logic               clk_b_d;
  logic               phase_start;

  assign phase_d     = phase_q + PHASE_W'(1);
  assign clk_a_d     = phase_d[1];
  assign clk_b_d     = phase_d[1] ^ phase_d[0];
  assign phase_start = tick && (phase_d == PHASE_RST);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      phase_q         <= PHASE_RST;
      LOCAL_CLOCK_A_O <= 1'b0;
      LOCAL_CLOCK_B_O <= 1'b0;
    end else if (tick) begin
      phase_q         <= phase_d;
      LOCAL_CLOCK_A_O <= clk_a_d;
      LOCAL_CLOCK_B_O <= clk_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request inputs
  // ----------------------------------------------------------------
  gspsc_sync_if #(.WIDTH(IRQ_N)) irq_bus ();

  assign irq_bus.raw = {EXT_IRQ_LEVEL_B_N_I, EXT_IRQ_LEVEL_A_N_I};
  assign irq_bus.en  = tick;

  gspsc_sync #(
    .WIDTH   (IRQ_N),
    .RST_VAL (IRQ_SYNC_RST)
  ) u_irq_sync (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .s      (irq_bus.sync)
  );

  // Active-low after sync; a request stays pending until acknowledged, and
  // a still-low input re-raises it in the very cycle of the acknowledge.
  logic [IRQ_N-1:0] irq_active;
  logic [IRQ_N-1:0] irq_pend_q;
  logic [IRQ_N-1:0] irq_pend_d;

  assign irq_active = ~irq_bus.synced;
  assign irq_pend_d = irq_active | (irq_pend_q & ~IRQ_ACK_I);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_pend_q <= IRQ_PEND_RST;
    end else begin
      irq_pend_q <= irq_pend_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      IRQ_REQ_O <= IRQ_PEND_RST;
    end else if (phase_start) begin
      IRQ_REQ_O[IRQ_LVL_A] <= irq_pend_q[IRQ_LVL_A];
      IRQ_REQ_O[IRQ_LVL_B] <= irq_pend_q[IRQ_LVL_B];
    end
  end

  // ----------------------------------------------------------------
  // Host-select capture and start-up sequence
  // ----------------------------------------------------------------
  // The strap is caught by the first clock after release; an async
  // reset may only load a constant into it.
  gspsc_state_t state_q;
  gspsc_state_t state_d;
  logic         host_sel_q;
  logic         halt_q;
  logic         halt_d;
  logic         halt_clear;
  logic         halt_set;

  assign halt_clear = HALT_BIT_WR_I && (HALT_BIT_WDATA_I == HALT_BIT_RUN);
  assign halt_set   = HALT_BIT_WR_I && (HALT_BIT_WDATA_I != HALT_BIT_RUN);

  always_comb begin
    state_d = state_q;
    halt_d  = halt_q;
    case (state_q)
      GSPSC_ST_RESET: begin
        state_d = GSPSC_ST_SAMPLE;
      end
      GSPSC_ST_SAMPLE: begin
        if (host_sel_q) begin
          state_d = GSPSC_ST_HALTED;
          halt_d  = ~HALT_BIT_RUN;
        end else begin
          state_d = GSPSC_ST_VECTOR;
        end
      end
      GSPSC_ST_VECTOR: begin
        if (phase_start) begin
          state_d = GSPSC_ST_RUN;
        end
      end
      GSPSC_ST_RUN: begin
        if (halt_set) begin
          state_d = GSPSC_ST_HALTED;
          halt_d  = ~HALT_BIT_RUN;
        end
      end
      GSPSC_ST_HALTED: begin
        if (halt_clear) begin
          state_d = GSPSC_ST_RUN;
          halt_d  = HALT_BIT_RUN;
        end
      end
      default: begin
        state_d = GSPSC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q    <= GSPSC_ST_RESET;
      host_sel_q <= HOST_SEL_RST;
      halt_q     <= HALT_BIT_RUN;
    end else begin
      if (state_q == GSPSC_ST_RESET) begin
        host_sel_q <= HOST_SELECT_STROBE_I;
      end
      state_q <= state_d;
      halt_q  <= halt_d;
    end
  end

  // ----------------------------------------------------------------
  // Start-up outputs, aligned to the local clock cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      VECTOR_FETCH_O <= 1'b0;
      RUN_O          <= 1'b0;
      HALT_BIT_O     <= 1'b0;
    end else if (phase_start) begin
      VECTOR_FETCH_O <= (state_q == GSPSC_ST_VECTOR);
      RUN_O          <= (state_q == GSPSC_ST_RUN) || (state_q == GSPSC_ST_VECTOR);
      HALT_BIT_O     <= halt_q;
    end else begin
      VECTOR_FETCH_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Video clock observation
  // ----------------------------------------------------------------
  // The video domain lives elsewhere; here its clock is only sampled to
  // give a rising-edge tick, which is valid only while it runs slower
  // than half the reference clock.
  logic video_clock_meta_q;
  logic video_clock_sync_q;
  logic video_clock_prev_q;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      video_clock_meta_q  <= 1'b0;
      video_clock_sync_q  <= 1'b0;
      video_clock_prev_q  <= 1'b0;
      VIDEO_TICK_O <= 1'b0;
    end else begin
      video_clock_meta_q  <= VIDEO_CLOCK_I;
      video_clock_sync_q  <= video_clock_meta_q;
      video_clock_prev_q  <= video_clock_sync_q;
      VIDEO_TICK_O <= video_clock_sync_q && !video_clock_prev_q;
    end
  end

endmodule
`default_nettype wire

// ===== gspsc_pkg.sv
// Constants and types shared by the system-control block
// Behaviour
// - Local clocks derive from reference clock input
// - Video logic uses separate asynchronous video clock
// - Local clocks are 90 degrees apart
// - Outputs change only with local clocks, except VECTOR_FETCH_O falling and VIDEO_TICK_O
// - Two interrupt inputs map to two levels
// - Asynchronous interrupt inputs synchronised before use
// - Reset loads all registers with initial values
// - Outputs inactive while reset is low
// - Host select sampled at reset release
// - Host select low: run from reset vector
// - Host select high: halt until halt bit cleared
package gspsc_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int          REF_CLK_MHZ     = 200;
  localparam int          PHASE_W         = 2;
  localparam int          QUARTER_W       = 8;
  localparam int          QUARTER_CYC_DEF = 1;
  localparam logic [1:0]  PHASE_RST       = 2'h0;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  localparam int          IRQ_N           = 2;
  localparam int          IRQ_LVL_A       = 0;
  localparam int          IRQ_LVL_B       = 1;
  localparam logic [1:0]  IRQ_SYNC_RST    = 2'h3;
  localparam logic [1:0]  IRQ_PEND_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Reset and start-up
  // ----------------------------------------------------------------
  localparam logic        HALT_BIT_RUN    = 1'b0;
  localparam logic        HOST_SEL_RST    = 1'b0;

  typedef enum logic [2:0] {
    GSPSC_ST_RESET,
    GSPSC_ST_SAMPLE,
    GSPSC_ST_VECTOR,
    GSPSC_ST_RUN,
    GSPSC_ST_HALTED
  } gspsc_state_t;

endpackage

// ===== gspsc_sync_if.sv
// Bundle between the system-control core and its synchroniser
`timescale 1ns/10ps
`default_nettype none
interface gspsc_sync_if #(
  parameter int WIDTH = 2
);
  logic [WIDTH-1:0] raw;
  logic             en;
  logic [WIDTH-1:0] synced;

  modport core (output raw, output en, input synced);
  modport sync (input raw, input en, output synced);
endinterface
`default_nettype wire

// ===== gspsc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module gspsc_sync
  import gspsc_pkg::*;
#(
  parameter int              WIDTH   = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  gspsc_sync_if.sync s
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (s.en) begin
      meta_q <= s.raw;
      sync_q <= meta_q;
    end
  end

  assign s.synced = sync_q;
endmodule
`default_nettype wire

// ===== gspsc_system_control_properties.sv
// Port-level checks for the system-control block
`timescale 1ns/10ps
`default_nettype none
module gspsc_system_control_properties
  import gspsc_pkg::*;
#(
  parameter int QUARTER_CYC = QUARTER_CYC_DEF
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RSTN_I,
  input wire logic       EXT_IRQ_LEVEL_A_N_I,
  input wire logic       EXT_IRQ_LEVEL_B_N_I,
  input wire logic       HOST_SELECT_STROBE_I,
  input wire logic       HALT_BIT_WR_I,
  input wire logic       HALT_BIT_WDATA_I,
  input wire logic       LOCAL_CLOCK_A_O,
  input wire logic       LOCAL_CLOCK_B_O,
  input wire logic [1:0] IRQ_REQ_O,
  input wire logic       VECTOR_FETCH_O,
  input wire logic       RUN_O,
  input wire logic       HALT_BIT_O,
  input wire logic       VIDEO_TICK_O
);
  localparam int PER  = 4 * QUARTER_CYC;
  localparam int MAXW = 3 * QUARTER_CYC + PER + 4;
  localparam int MAXS = PER + 5;
  // No async edge clears the flops at time zero, so skip the first clock
  bit armed_q = 1'b0;
  always @(posedge CLK_SYS_I) armed_q <= 1'b1;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_start; $fell(LOCAL_CLOCK_A_O); endsequence
  sequence s_free; HALT_BIT_O && HALT_BIT_WR_I && !HALT_BIT_WDATA_I; endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) armed_q && !RSTN_I |->
    {LOCAL_CLOCK_A_O, LOCAL_CLOCK_B_O, IRQ_REQ_O, VECTOR_FETCH_O, RUN_O, HALT_BIT_O} == 7'h00)
    else $error("outputs active during reset");
  chk_clock_quad: assert property ($changed(LOCAL_CLOCK_A_O) |-> $stable(LOCAL_CLOCK_B_O))
    else $error("local clocks toggled together");
  chk_clock_order: assert property ($rose(LOCAL_CLOCK_A_O) |-> LOCAL_CLOCK_B_O)
    else $error("clock a rose without b leading");
  chk_clock_period: assert property ($rose(LOCAL_CLOCK_A_O) |-> ##PER $rose(LOCAL_CLOCK_A_O))
    else $error("local clock period wrong");
  chk_outputs_sync: assert property ($changed({IRQ_REQ_O, RUN_O, HALT_BIT_O}) |-> s_start)
    else $error("output moved off the local cycle start");
  chk_irq_a_answer: assert property ($fell(EXT_IRQ_LEVEL_A_N_I) |-> ##[1:MAXW] IRQ_REQ_O[0])
    else $error("level a request not raised");
  chk_irq_b_answer: assert property ($fell(EXT_IRQ_LEVEL_B_N_I) |-> ##[1:MAXW] IRQ_REQ_O[1])
    else $error("level b request not raised");
  chk_irq_sync_a: assert property ($rose(IRQ_REQ_O[0]) |-> !$past(EXT_IRQ_LEVEL_A_N_I, 3))
    else $error("level a request faster than synchroniser");
  chk_irq_sync_b: assert property ($rose(IRQ_REQ_O[1]) |-> !$past(EXT_IRQ_LEVEL_B_N_I, 3))
    else $error("level b request faster than synchroniser");
  chk_start_vector: assert property ($rose(RSTN_I) && !HOST_SELECT_STROBE_I |-> ##[1:MAXS] VECTOR_FETCH_O)
    else $error("no vector fetch after reset");
  chk_vector_pulse: assert property (VECTOR_FETCH_O |-> (RUN_O && !HALT_BIT_O) ##1 !VECTOR_FETCH_O)
    else $error("vector fetch pulse wrong");
  chk_start_halt: assert property ($rose(RSTN_I) && HOST_SELECT_STROBE_I |->
    !RUN_O throughout (##[1:MAXS] HALT_BIT_O)) else $error("host start did not halt");
  chk_halt_hold: assert property (HALT_BIT_O |-> !RUN_O && !VECTOR_FETCH_O)
    else $error("running while halted");
  chk_halt_free: assert property (s_free |-> ##[1:MAXW] (RUN_O && !HALT_BIT_O))
    else $error("halt not released");
  chk_video_pulse: assert property (VIDEO_TICK_O |=> !VIDEO_TICK_O)
    else $error("video tick longer than one cycle");
endmodule
`default_nettype wire

// ===== gspsc_partner.sv
// Interrupt sources standing at the far side of the block
`timescale 1ns/10ps
`default_nettype none
module gspsc_partner (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] fire_i,
  input  wire logic [3:0] dly_i,
  input  wire logic [1:0] irq_req_i,
  output var  logic [1:0] irq_n_o,
  output var  logic [1:0] ack_o
);
  logic [1:0] low_q;
  logic [3:0] cnt_q [2];
  assign irq_n_o = ~low_q;
  // Ack waits dly_i cycles so the synchroniser has seen the line go high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_q <= 2'h0;
      ack_o <= 2'h0;
      cnt_q <= '{4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        ack_o[i] <= (cnt_q[i] == 4'h1);
        if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
        if (fire_i[i]) low_q[i] <= 1'b1;
        else if (low_q[i] && irq_req_i[i]) begin
          low_q[i] <= 1'b0;
          cnt_q[i] <= dly_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== gspsc_system_control_tb.sv
// Self-checking bench for the system-control block
`timescale 1ns/10ps
`default_nettype none
module gspsc_system_control_tb;
  import gspsc_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, video_clock = 1'b0, strap = 1'b0, hwr = 1'b0, hwd = 1'b0;
  logic [1:0] fire = 2'h0, req, ack, irq_n, p;
  logic [3:0] dly = 4'h4;
  logic       lca, lcb, vf, run, halt, vt;
  int         bad_count = 0, compares = 0, n, vcnt;
  initial forever #2.5 clk = ~clk;
  initial forever #7.1 video_clock = ~video_clock;
  gspsc_system_control #(.QUARTER_CYC(1)) uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .VIDEO_CLOCK_I(video_clock),
    .EXT_IRQ_LEVEL_A_N_I(irq_n[0]), .EXT_IRQ_LEVEL_B_N_I(irq_n[1]), .IRQ_ACK_I(ack),
    .HOST_SELECT_STROBE_I(strap), .HALT_BIT_WR_I(hwr), .HALT_BIT_WDATA_I(hwd), .LOCAL_CLOCK_A_O(lca),
    .LOCAL_CLOCK_B_O(lcb), .IRQ_REQ_O(req), .VECTOR_FETCH_O(vf), .RUN_O(run), .HALT_BIT_O(halt),
    .VIDEO_TICK_O(vt));
  gspsc_partner u_src (.clk_i(clk), .rstn_i(rstn), .fire_i(fire), .dly_i(dly), .irq_req_i(req),
    .irq_n_o(irq_n), .ack_o(ack));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_reset(input logic s);
    rstn = 1'b0;
    strap = s;
    tick(10);
    check("outputs in reset", {lca, lcb, req, vf, run, halt, vt}, 8'h00);
    rstn = 1'b1;
  endtask
  task automatic hwrite(input logic d);
    hwd = d;
    hwr = 1'b1;
    tick(1);
    hwr = 1'b0;
  endtask
  task automatic t_vector();
    t_reset(1'b0);
    for (n = 0; n < 20 && vf !== 1'b1; n++) tick(1);
    check("vector fetch", {7'h0, vf}, 8'h01);
    check("run after vector", {6'h0, run, halt}, 8'h02);
    // Each cycle must take one step along the quadrature sequence
    for (n = 0; n < 16; n++) begin
      p = {lca, lcb};
      tick(1);
      check("local clock step", {6'h0, lca, lcb}, {6'h0, p[0], ~p[1]});
    end
  endtask
  task automatic t_video();
    vcnt = 0;
    for (n = 0; n < 140; n++) begin
      tick(1);
      vcnt += int'(vt === 1'b1);
    end
    check("video ticks", {7'h0, vcnt >= 48 && vcnt <= 51}, 8'h01);
  endtask
  task automatic t_irq(input logic [1:0] which, input logic [3:0] d);
    dly = d;
    fire = which;
    tick(1);
    fire = 2'h0;
    for (n = 0; n < 30 && req !== which; n++) tick(1);
    check("request levels", {6'h0, req}, {6'h0, which});
    for (n = 0; n < 40 && req !== 2'h0; n++) tick(1);
    check("request cleared", {6'h0, req}, 8'h00);
  endtask
  task automatic t_host();
    t_reset(1'b1);
    hwrite(1'b0);
    strap = 1'b0;
    tick(12);
    check("halted after host start", {5'h0, run, halt, vf}, 8'h02);
    hwrite(1'b0);
    tick(8);
    check("released by host", {6'h0, run, halt}, 8'h02);
    hwrite(1'b1);
    tick(8);
    check("halted again", {6'h0, run, halt}, 8'h01);
  endtask
  initial begin
    t_vector();
    t_video();
    t_irq(2'h1, 4'h4);
    t_irq(2'h2, 4'hc);
    t_irq(2'h3, 4'h6);
    t_host();
    conclude();
  end
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule
bind gspsc_system_control gspsc_system_control_properties #(.QUARTER_CYC(QUARTER_CYC)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .EXT_IRQ_LEVEL_A_N_I(EXT_IRQ_LEVEL_A_N_I),
  .EXT_IRQ_LEVEL_B_N_I(EXT_IRQ_LEVEL_B_N_I), .HOST_SELECT_STROBE_I(HOST_SELECT_STROBE_I),
  .HALT_BIT_WR_I(HALT_BIT_WR_I), .HALT_BIT_WDATA_I(HALT_BIT_WDATA_I), .LOCAL_CLOCK_A_O(LOCAL_CLOCK_A_O),
  .LOCAL_CLOCK_B_O(LOCAL_CLOCK_B_O), .IRQ_REQ_O(IRQ_REQ_O), .VECTOR_FETCH_O(VECTOR_FETCH_O),
  .RUN_O(RUN_O), .HALT_BIT_O(HALT_BIT_O), .VIDEO_TICK_O(VIDEO_TICK_O));
`default_nettype wire
